// ### verilog/bsiu_params.svh
// constants for the boundary-scan instruction unit
`ifndef BSIU_PARAMS_SVH
`define BSIU_PARAMS_SVH

// instruction register
`define BSIU_IR_LEN            10
`define BSIU_IR_CAPTURE        10'h001

// instruction codes
`define BSIU_OP_SAMPLE         10'h005
`define BSIU_OP_EXTEST         10'h00f
`define BSIU_OP_BYPASS         10'h3ff
`define BSIU_OP_USERCODE       10'h007
`define BSIU_OP_IDCODE         10'h006
`define BSIU_OP_HIGHZ          10'h00b
`define BSIU_OP_CLAMP          10'h00a
`define BSIU_OP_RECONFIG       10'h001
`define BSIU_OP_CONFIG_IO      10'h00d

// data register lengths
`define BSIU_ID_LEN            32
`define BSIU_USERCODE_LEN      32

// identification word fields: version, part, maker, fixed lsb
`define BSIU_ID_VER_POS        28
`define BSIU_ID_PART_POS       12
`define BSIU_ID_MFR_POS        1
`define BSIU_ID_LSB            1'b1

// deepest chain position at which configuration through the port works
`define BSIU_CHAIN_MAX_POS     8

`endif

// ### verilog/bsiu_pkg.sv
// types shared by the boundary-scan instruction unit
package bsiu_pkg;

	typedef enum logic [3:0] {
		BSIU_TLR   = 4'h0,
		BSIU_RTI   = 4'h1,
		BSIU_SELDR = 4'h2,
		BSIU_CAPDR = 4'h3,
		BSIU_SHDR  = 4'h4,
		BSIU_EX1DR = 4'h5,
		BSIU_PSDR  = 4'h6,
		BSIU_EX2DR = 4'h7,
		BSIU_UPDR  = 4'h8,
		BSIU_SELIR = 4'h9,
		BSIU_CAPIR = 4'ha,
		BSIU_SHIR  = 4'hb,
		BSIU_EX1IR = 4'hc,
		BSIU_PSIR  = 4'hd,
		BSIU_EX2IR = 4'he,
		BSIU_UPIR  = 4'hf
	} bsiu_tap_t;

	typedef enum logic [2:0] {
		BSIU_DR_BYPASS = 3'h0,
		BSIU_DR_BOUND  = 3'h1,
		BSIU_DR_IDENT  = 3'h2,
		BSIU_DR_USER   = 3'h3,
		BSIU_DR_IOSTD  = 3'h4
	} bsiu_dr_t;

endpackage : bsiu_pkg

// ### verilog/bsiu_tap_if.sv
// link between the tap state machine and the instruction unit
`timescale 1ns/10ps
interface bsiu_tap_if;
	import bsiu_pkg::*;
	logic      tck_rise;
	logic      tck_fall;
	logic      tms;
	bsiu_tap_t state;

	modport ctl  (input tck_rise, input tck_fall, input tms, output state);
	modport user (output tck_rise, output tck_fall, output tms, input state);
endinterface : bsiu_tap_if

// ### verilog/bsiu_tap.sv
// test access port state machine, stepped on each sampled rising test clock
`timescale 1ns/10ps
module bsiu_tap (
	input  wire logic sys_clk,
	input  wire logic rst,
	bsiu_tap_if.ctl   tap
);
	import bsiu_pkg::*;

	typedef struct packed {
		bsiu_tap_t state;
	} bsiu_tap_st_t;

	bsiu_tap_st_t st;
	bsiu_tap_st_t next_st;

	function automatic bsiu_tap_t bsiu_step(input bsiu_tap_t s, input logic m);
		case (s)
			BSIU_TLR:   bsiu_step = m ? BSIU_TLR   : BSIU_RTI;
			BSIU_RTI:   bsiu_step = m ? BSIU_SELDR : BSIU_RTI;
			BSIU_SELDR: bsiu_step = m ? BSIU_SELIR : BSIU_CAPDR;
			BSIU_CAPDR: bsiu_step = m ? BSIU_EX1DR : BSIU_SHDR;
			BSIU_SHDR:  bsiu_step = m ? BSIU_EX1DR : BSIU_SHDR;
			BSIU_EX1DR: bsiu_step = m ? BSIU_UPDR  : BSIU_PSDR;
			BSIU_PSDR:  bsiu_step = m ? BSIU_EX2DR : BSIU_PSDR;
			BSIU_EX2DR: bsiu_step = m ? BSIU_UPDR  : BSIU_SHDR;
			BSIU_UPDR:  bsiu_step = m ? BSIU_SELDR : BSIU_RTI;
			BSIU_SELIR: bsiu_step = m ? BSIU_TLR   : BSIU_CAPIR;
			BSIU_CAPIR: bsiu_step = m ? BSIU_EX1IR : BSIU_SHIR;
			BSIU_SHIR:  bsiu_step = m ? BSIU_EX1IR : BSIU_SHIR;
			BSIU_EX1IR: bsiu_step = m ? BSIU_UPIR  : BSIU_PSIR;
			BSIU_PSIR:  bsiu_step = m ? BSIU_EX2IR : BSIU_PSIR;
			BSIU_EX2IR: bsiu_step = m ? BSIU_UPIR  : BSIU_SHIR;
			BSIU_UPIR:  bsiu_step = m ? BSIU_SELDR : BSIU_RTI;
			default:    bsiu_step = BSIU_TLR;
		endcase
	endfunction : bsiu_step

	always_comb
	begin
		next_st = st;
		if (tap.tck_rise)
			next_st.state = bsiu_step(st.state, tap.tms); // RQ19
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			st <= '{state: BSIU_TLR};
		else
			st <= next_st;
	end

	assign tap.state = st.state;
endmodule : bsiu_tap

// ### verilog/bsiu_unit.sv
// boundary-scan instruction unit: pin sampling, instruction decode, data registers, pin effects
//
// Notes on behaviour
// RQ1: no pin test while configuration runs
// RQ2: chain rewrites pin i/o standards anytime
// RQ3: all four test port signals are used
// RQ4: clock pulled low, data and mode high
// RQ5: board places device in first eight
// RQ6: sample captures pins, allows preload pattern
// RQ7: extest drives outputs, captures inputs
// RQ8: bypass gives one-bit, one-clock path
// RQ9: usercode shifts out 32-bit user word
// RQ10: idcode shifts out identification word
// RQ11: highz bypasses and floats every pin
// RQ12: clamp bypasses, pins hold boundary levels
// RQ13: reconfig instruction acts like request pulse
// RQ14: instruction register is ten bits
// RQ15: config_io loads standards, halts, holds status
// RQ16: keepers and pull-ups override test float
// RQ17: identification word lsb reads one
// RQ18: unknown codes act as bypass
// RQ19: standard tap states, timing and reset
`timescale 1ns/10ps
`include "bsiu_params.svh"
module bsiu_unit #(
	parameter int          NUM_PINS    = 8,
	parameter int          IOSTD_LEN   = 16,
	parameter logic [3:0]  ID_VERSION  = 4'h0,
	parameter logic [15:0] ID_PART     = 16'h1234,   // arbitrary value
	parameter logic [10:0] ID_MAKER    = 11'h2aa     // arbitrary value
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire logic                    tck,
	input  wire logic                    tms,
	input  wire logic                    tdi,
	output logic                         tdo,
	output logic                         tdo_oe,
	output logic                         tck_pull_down,
	output logic                         tms_pull_up,
	output logic                         tdi_pull_up,
	input  wire logic                    reconfig_request_pin_n,
	input  wire logic                    config_busy,
	input  wire logic [`BSIU_USERCODE_LEN-1:0] user_code,
	input  wire logic [NUM_PINS-1:0]     core_out,
	input  wire logic [NUM_PINS-1:0]     core_oe,
	input  wire logic [NUM_PINS-1:0]     pin_in,
	input  wire logic [NUM_PINS-1:0]     pin_keep_en,
	output logic [NUM_PINS-1:0]          pin_out,
	output logic [NUM_PINS-1:0]          pin_oe,
	output logic [NUM_PINS-1:0]          pin_keeper_on,
	output logic [IOSTD_LEN-1:0]         io_std_cfg,
	output logic                         reconfig_start,
	output logic                         config_halt,
	output logic                         config_status_low
);
	import bsiu_pkg::*;

	localparam int BND_LEN = 2 * NUM_PINS;
	localparam int IRW     = `BSIU_IR_LEN;
	localparam int IDW     = `BSIU_ID_LEN;

	// cell 2i holds pin data, cell 2i+1 holds its output enable
	typedef struct packed {
		logic [2:0]           tck_sync;
		logic [1:0]           tms_sync;
		logic [1:0]           tdi_sync;
		logic [1:0]           ncfg_sync;
		logic [NUM_PINS-1:0]  pin_s1;
		logic [NUM_PINS-1:0]  pin_s2;
		logic [IRW-1:0]       ir_sh;
		logic [IRW-1:0]       ir;
		logic                 byp;
		logic [IDW-1:0]       id_sh;
		logic [BND_LEN-1:0]   bnd_sh;
		logic [BND_LEN-1:0]   bnd_upd;
		logic [IOSTD_LEN-1:0] iostd_sh;
		logic [IOSTD_LEN-1:0] iostd_upd;
		logic                 tdo;
		logic                 tdo_oe;
		logic [NUM_PINS-1:0]  pin_out;
		logic [NUM_PINS-1:0]  pin_oe;
		logic [NUM_PINS-1:0]  keeper;
		logic                 reconfig_start;
		logic                 config_halt;
		logic                 status_low;
		logic                 pulls;
	} bsiu_st_t;

	bsiu_st_t st;
	bsiu_st_t next_st;

	bsiu_tap_if tap_link ();

	bsiu_tap u_tap (
		.sys_clk (sys_clk),
		.rst     (rst),
		.tap     (tap_link.ctl)
	);

	// decoding for data register selection; pin control compares the instruction directly
	function automatic bsiu_dr_t bsiu_select(input logic [IRW-1:0] op);
		case (op)
			`BSIU_OP_SAMPLE:    bsiu_select = BSIU_DR_BOUND;   // RQ6
			`BSIU_OP_EXTEST:    bsiu_select = BSIU_DR_BOUND;   // RQ7
			`BSIU_OP_USERCODE:  bsiu_select = BSIU_DR_USER;    // RQ9
			`BSIU_OP_IDCODE:    bsiu_select = BSIU_DR_IDENT;   // RQ10
			`BSIU_OP_CONFIG_IO: bsiu_select = BSIU_DR_IOSTD;   // RQ15
			`BSIU_OP_HIGHZ:     bsiu_select = BSIU_DR_BYPASS;  // RQ11
			`BSIU_OP_CLAMP:     bsiu_select = BSIU_DR_BYPASS;  // RQ12
			`BSIU_OP_BYPASS:    bsiu_select = BSIU_DR_BYPASS;  // RQ8
			default:            bsiu_select = BSIU_DR_BYPASS;  // RQ18
		endcase
	endfunction : bsiu_select

	function automatic logic bsiu_is(input logic [IRW-1:0] op, input logic [IRW-1:0] code);
		bsiu_is = (op == code);
	endfunction : bsiu_is

	logic                tck_rise;
	logic                tck_fall;
	bsiu_tap_t           tstate;
	bsiu_dr_t            dr_sel;
	logic [IDW-1:0]      ident_word;
	logic                pin_test_ok;
	logic                mode_force;
	logic                mode_float;
	logic [NUM_PINS-1:0] drv_out;
	logic [NUM_PINS-1:0] drv_oe;

	// edges come from the second and third sync stages only, never the first
	assign tck_rise = st.tck_sync[1] & ~st.tck_sync[2];
	assign tck_fall = ~st.tck_sync[1] & st.tck_sync[2];

	assign tap_link.tck_rise = tck_rise;  // RQ3
	assign tap_link.tck_fall = tck_fall;
	assign tap_link.tms      = st.tms_sync[1];
	assign tstate            = tap_link.state;

	assign dr_sel     = bsiu_select(st.ir);
	assign ident_word = {ID_VERSION, ID_PART, ID_MAKER, `BSIU_ID_LSB};  // RQ17

	// pin tests are held off while configuration is loading
	assign pin_test_ok = ~config_busy;  // RQ1
	assign mode_force  = pin_test_ok & (bsiu_is(st.ir, `BSIU_OP_EXTEST)
		| bsiu_is(st.ir, `BSIU_OP_CLAMP));  // RQ7 RQ12
	assign mode_float  = pin_test_ok & bsiu_is(st.ir, `BSIU_OP_HIGHZ);  // RQ11

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++)
		begin : g_pin
			assign drv_out[gi] = mode_force ? st.bnd_upd[2*gi] : core_out[gi];
			assign drv_oe[gi]  = mode_float ? 1'b0
				: (mode_force ? st.bnd_upd[2*gi+1] : core_oe[gi]);
		end
	endgenerate

	always_comb
	begin
		next_st = st;
		next_st.reconfig_start = 1'b0;

		next_st.tck_sync  = {st.tck_sync[1:0], tck};
		next_st.tms_sync  = {st.tms_sync[0], tms};
		next_st.tdi_sync  = {st.tdi_sync[0], tdi};
		next_st.ncfg_sync = {st.ncfg_sync[0], reconfig_request_pin_n};
		next_st.pin_s1    = pin_in;
		next_st.pin_s2    = st.pin_s1;

		// capture and shift on the rising test clock
		if (tck_rise)
		begin
			case (tstate)
				BSIU_CAPIR:
					next_st.ir_sh = `BSIU_IR_CAPTURE;  // RQ14
				BSIU_SHIR:
					next_st.ir_sh = {st.tdi_sync[1], st.ir_sh[IRW-1:1]};  // RQ14
				BSIU_CAPDR:
				begin
					case (dr_sel)
						BSIU_DR_BOUND:
						begin
							// a running configuration leaves the chain contents alone
							if (pin_test_ok)
							begin
								for (int k = 0; k < NUM_PINS; k++)
								begin
									next_st.bnd_sh[2*k]   = st.pin_s2[k];  // RQ6 RQ7
									next_st.bnd_sh[2*k+1] = core_oe[k];
								end
							end
						end
						BSIU_DR_IDENT:
							next_st.id_sh = ident_word;  // RQ10
						BSIU_DR_USER:
							next_st.id_sh = user_code;  // RQ9
						BSIU_DR_IOSTD:
							next_st.iostd_sh = st.iostd_upd;
						default:
							next_st.byp = 1'b0;  // RQ8
					endcase
				end
				BSIU_SHDR:
				begin
					case (dr_sel)
						BSIU_DR_BOUND:
							next_st.bnd_sh = {st.tdi_sync[1], st.bnd_sh[BND_LEN-1:1]};  // RQ6
						BSIU_DR_IDENT,
						BSIU_DR_USER:
							next_st.id_sh = {st.tdi_sync[1], st.id_sh[IDW-1:1]};  // RQ9 RQ10
						BSIU_DR_IOSTD:
							next_st.iostd_sh = {st.tdi_sync[1], st.iostd_sh[IOSTD_LEN-1:1]};
						default:
							next_st.byp = st.tdi_sync[1];  // RQ8
					endcase
				end
				default:
					next_st.byp = st.byp;
			endcase
		end

		// update and output on the falling test clock
		if (tck_fall)
		begin
			case (tstate)
				BSIU_TLR:
					next_st.ir = `BSIU_OP_IDCODE;  // RQ19
				BSIU_UPIR:
				begin
					next_st.ir = st.ir_sh;
					if (bsiu_is(st.ir_sh, `BSIU_OP_RECONFIG))
						next_st.reconfig_start = 1'b1;  // RQ13
					if (bsiu_is(st.ir_sh, `BSIU_OP_CONFIG_IO))
					begin
						next_st.config_halt = 1'b1;  // RQ15
						next_st.status_low  = 1'b1;  // RQ15
					end
				end
				BSIU_UPDR:
				begin
					if (dr_sel == BSIU_DR_BOUND && pin_test_ok)
						next_st.bnd_upd = st.bnd_sh;  // RQ6 RQ7
					if (dr_sel == BSIU_DR_IOSTD)
						next_st.iostd_upd = st.iostd_sh;  // RQ2 RQ15
				end
				default:
					next_st.ir = st.ir;
			endcase

			next_st.tdo_oe = (tstate == BSIU_SHIR) || (tstate == BSIU_SHDR);
			if (tstate == BSIU_SHIR)
				next_st.tdo = st.ir_sh[0];
			else
			begin
				case (dr_sel)
					BSIU_DR_BOUND:  next_st.tdo = st.bnd_sh[0];
					BSIU_DR_IDENT,
					BSIU_DR_USER:   next_st.tdo = st.id_sh[0];
					BSIU_DR_IOSTD:  next_st.tdo = st.iostd_sh[0];
					default:        next_st.tdo = st.byp;  // RQ8
				endcase
			end
		end

		// a restart of configuration ends the halt; a fresh set in the same cycle wins
		if ((~st.ncfg_sync[1] || st.reconfig_start) && !(tck_fall && tstate == BSIU_UPIR
			&& bsiu_is(st.ir_sh, `BSIU_OP_CONFIG_IO)))
		begin
			next_st.config_halt = 1'b0;
			next_st.status_low  = 1'b0;
		end

		next_st.pin_out = drv_out;
		next_st.pin_oe  = drv_oe;
		next_st.keeper  = pin_keep_en;  // RQ16
		next_st.pulls   = 1'b1;  // RQ4
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			st           <= '0;
			st.ir        <= `BSIU_OP_IDCODE;  // RQ19
			st.ncfg_sync <= 2'h3;
			st.pulls     <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign tdo               = st.tdo;
	assign tdo_oe            = st.tdo_oe;
	assign tck_pull_down     = st.pulls;  // RQ4
	assign tms_pull_up       = st.pulls;
	assign tdi_pull_up       = st.pulls;
	assign pin_out           = st.pin_out;
	assign pin_oe            = st.pin_oe;
	assign pin_keeper_on     = st.keeper;  // RQ16
	assign io_std_cfg        = st.iostd_upd;
	assign reconfig_start    = st.reconfig_start;
	assign config_halt       = st.config_halt;
	assign config_status_low = st.status_low;
endmodule : bsiu_unit

// ### verif/bsiu_host.sv
// scan host model: drives the test port and collects serial data
`timescale 1ns/10ps
module bsiu_host (
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	// a single device on the chain, so it sits in position one
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// tdo is taken just before the fall, when the previous fall's bit has long settled
	task automatic step(input logic m, input logic d, output logic o);
		tms = m;
		tdi = d;
		#100 tck = 1'b1;
		#99 o = tdo;
		#1 tck = 1'b0;
	endtask : step

	// from run-test-idle through one scan, lsb first, and back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic o;
		dout = '0;
		step(1'b1, 1'b1, o);
		if (ir)
			step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		// released lines fall back to their pull levels; tck stays low
		tms = 1'b1;
		tdi = 1'b1;
		// one idle test clock period, so a following scan never re-drives in this step
		#200;
	endtask : scan

	task automatic tap_reset();
		logic o;
		repeat (5) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask : tap_reset
endmodule : bsiu_host

// ### verif/bsiu_props.sv
// concurrent checks on the pins of the boundary-scan instruction unit
`timescale 1ns/10ps
module bsiu_props #(
	parameter int NUM_PINS = 8
) (
	input wire logic                sys_clk,
	input wire logic                rst,
	input wire logic                tck,
	input wire logic                tdo,
	input wire logic                tdo_oe,
	input wire logic                tck_pull_down,
	input wire logic                tms_pull_up,
	input wire logic                tdi_pull_up,
	input wire logic                reconfig_request_pin_n,
	input wire logic                config_busy,
	input wire logic [NUM_PINS-1:0] core_out,
	input wire logic [NUM_PINS-1:0] core_oe,
	input wire logic [NUM_PINS-1:0] pin_keep_en,
	input wire logic [NUM_PINS-1:0] pin_out,
	input wire logic [NUM_PINS-1:0] pin_oe,
	input wire logic [NUM_PINS-1:0] pin_keeper_on,
	input wire logic                reconfig_start,
	input wire logic                config_halt,
	input wire logic                config_status_low
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_pulls_on: assert property (
		tck_pull_down && tms_pull_up && tdi_pull_up) else $error("pad pulls off");
	// serial outputs move only while the test clock has been low a while
	chk_tdo_at_fall: assert property (
		$changed(tdo) |-> !$past(tck, 2)) else $error("tdo moved near a rise");
	chk_oe_at_fall: assert property (
		$changed(tdo_oe) |-> !$past(tck, 2)) else $error("tdo_oe moved near a rise");
	chk_keeper_wins: assert property (
		!$past(rst) |-> pin_keeper_on == $past(pin_keep_en)) else $error("keeper lost");
	chk_busy_core: assert property (
		$past(config_busy) && !$past(rst) |-> pin_out == $past(core_out)
		&& pin_oe == $past(core_oe)) else $error("test pins while configuring");
	chk_start_pulse: assert property (
		reconfig_start |=> !reconfig_start) else $error("start pulse too long");
	chk_start_on_fall: assert property (
		$rose(reconfig_start) |-> !$past(tck, 2)) else $error("start away from update");
	chk_halt_pair: assert property (
		config_halt == config_status_low) else $error("halt and status differ");
	chk_halt_freed: assert property (
		!reconfig_request_pin_n [*3] |=> !config_halt) else $error("halt not freed");
endmodule : bsiu_props

bind bsiu_unit bsiu_props #(.NUM_PINS(NUM_PINS)) u_props (.*);

// ### verif/tb_top.sv
// self-checking bench for the boundary-scan instruction unit
`timescale 1ns/10ps
`include "bsiu_params.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
	localparam logic [3:0]  VER  = 4'h0;
	localparam logic [15:0] PART = 16'h5a3c;  // arbitrary value
	localparam logic [10:0] MAKR = 11'h155;   // arbitrary value
	localparam logic [15:0] PRE  = 16'h6c93;
	logic        sys_clk, rst, tck, tms, tdi, tdo, tdo_oe, reconfig_start;
	logic        tck_pull_down, tms_pull_up, tdi_pull_up, config_busy;
	logic        reconfig_request_pin_n, config_halt, config_status_low;
	logic [31:0] user_code, d;
	logic [7:0]  core_out, core_oe, pin_in, pin_keep_en, pin_out, pin_oe, pin_keeper_on;
	logic [15:0] io_std_cfg;
	int          n_errors = 0, checked = 0, n_pulse = 0, n_oe = 0;

	bsiu_unit #(.NUM_PINS(8), .IOSTD_LEN(16), .ID_VERSION(VER), .ID_PART(PART),
		.ID_MAKER(MAKR)) DUT (.*);
	bsiu_host HOST (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		if (reconfig_start === 1'b1)
			n_pulse++;
		if (tdo_oe === 1'b1)
			n_oe++;
	end

	function automatic logic [15:0] cells(input logic [7:0] dat, input logic [7:0] en);
		for (int i = 0; i < 8; i++)
			cells[2*i +: 2] = {en[i], dat[i]};
	endfunction : cells

	function automatic logic [7:0] half(input logic [15:0] v, input int odd);
		for (int i = 0; i < 8; i++)
			half[i] = v[2*i+odd];
	endfunction : half

	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	task automatic ir_load(input logic [9:0] code);
		HOST.scan(1'b1, 10, {22'h0, code}, d);
		`CHK("ir capture", `BSIU_IR_CAPTURE, d[9:0])
	endtask : ir_load

	task automatic pins(input logic [7:0] o, input logic [7:0] e);
		`CHK("pin_out", o, pin_out)
		`CHK("pin_oe", e, pin_oe)
	endtask : pins

	task automatic t_ident();
		int n0;
		HOST.tap_reset();
		n0 = n_oe;
		HOST.scan(1'b0, 32, 32'h0, d);
		`CHK("ident", {VER, PART, MAKR, `BSIU_ID_LSB}, d)
		// oe stands one test clock period (8 system clocks) per shifted bit
		`CHK("tdo_oe span", 32 * 8, n_oe - n0)
		`CHK("ident lsb", 1'b1, d[0])
		`CHK("pulls", 3'b111, {tck_pull_down, tms_pull_up, tdi_pull_up})
		ir_load(`BSIU_OP_USERCODE);
		HOST.scan(1'b0, 32, 32'h0, d);
		`CHK("usercode", user_code, d)
	endtask : t_ident

	// preload under sample, then drive it out under extest
	task automatic t_bound();
		ir_load(`BSIU_OP_SAMPLE);
		HOST.scan(1'b0, 16, {16'h0, PRE}, d);
		`CHK("sample", cells(pin_in, core_oe), d[15:0])
		pins(core_out, core_oe);
		ir_load(`BSIU_OP_EXTEST);
		pins(half(PRE, 0), half(PRE, 1));
		HOST.scan(1'b0, 16, {16'h0, PRE}, d);
		`CHK("extest", cells(pin_in, core_oe), d[15:0])
	endtask : t_bound

	task automatic t_bypass();
		logic [9:0] codes[4] = '{`BSIU_OP_BYPASS, 10'h2c3, `BSIU_OP_HIGHZ, `BSIU_OP_CLAMP};
		for (int k = 0; k < 4; k++)
		begin
			ir_load(codes[k]);
			HOST.scan(1'b0, 8, 32'h96, d);
			`CHK("bypass", 8'h2c, d[7:0])
			if (k == 2)
			begin
				`CHK("highz oe", 8'h00, pin_oe)
				`CHK("keeper", pin_keep_en, pin_keeper_on)
			end
			else if (k == 3)
				pins(half(PRE, 0), half(PRE, 1));
			else
				pins(core_out, core_oe);
		end
	endtask : t_bypass

	// test modes are refused while configuring; i/o standards are not
	task automatic t_config();
		int n0;
		config_busy = 1'b1;
		ir_load(`BSIU_OP_EXTEST);
		pins(core_out, core_oe);
		ir_load(`BSIU_OP_CONFIG_IO);
		`CHK("halt", 2'b11, {config_halt, config_status_low})
		HOST.scan(1'b0, 16, 32'hbeef, d);
		`CHK("iostd capture", 16'h0, d[15:0])
		`CHK("iostd", 16'hbeef, io_std_cfg)
		config_busy = 1'b0;
		ir_load(`BSIU_OP_BYPASS);
		`CHK("halt held", 2'b11, {config_halt, config_status_low})
		reconfig_request_pin_n = 1'b0;
		repeat (6) @(posedge sys_clk);
		#2;
		`CHK("halt freed", 2'b00, {config_halt, config_status_low})
		reconfig_request_pin_n = 1'b1;
		n0 = n_pulse;
		ir_load(`BSIU_OP_RECONFIG);
		`CHK("reconfig pulses", n0 + 1, n_pulse)
		`CHK("start released", 1'b0, reconfig_start)
	endtask : t_config

	initial
	begin
		rst = 1'b1;
		reconfig_request_pin_n = 1'b1;
		config_busy = 1'b0;
		user_code = 32'hc0de4a17;
		core_out = 8'h3a;
		core_oe = 8'hc5;
		pin_in = 8'h69;
		pin_keep_en = 8'hf0;
		repeat (16) @(posedge sys_clk);
		#2 rst = 1'b0;
		repeat (3) @(posedge sys_clk);
		#2;
		t_ident();
		t_bound();
		t_bypass();
		t_config();
		end_of_test();
	end

	initial
	begin
		#1000000;
		n_errors++;
		$display("ERROR watchdog expected done seen hang");
		end_of_test();
	end
endmodule : tb_top
